/* File: include/mnx_consts.svh */
`ifndef MNX_CONSTS_SVH
`define MNX_CONSTS_SVH
`define MNX_OPC_MUL_HI   7'h01
`define MNX_OPC_NEG_HI   7'h36
`define MNX_OPC_POP      16'h0006
`define MNX_OPC_PUSH     16'h0005
`define MNX_OPC_NOP      16'h0000
`define MNX_NOP_NIBBLE   4'hf
`define MNX_PC_STEP      21'h000002
`define MNX_STACK_DEPTH  31
`define MNX_SP_W         5
`define MNX_FLAG_C       0
`define MNX_FLAG_DC      1
`define MNX_FLAG_Z       2
`define MNX_FLAG_OV      3
`define MNX_FLAG_N       4
`define MNX_ACCESS_SPLIT 8'h80
`define MNX_ACCESS_HIGH  4'hf
`define MNX_ACCESS_LOW   4'h0
`define MNX_NEG_OVF_VAL  8'h80
`endif

/* File: include/mnx_pkg.sv */
package mnx_pkg;
   typedef struct packed {
      logic [3:0] bank;
      logic [7:0] offset;
   } mnx_addr_t;

   typedef struct packed {
      logic [15:0] word;
      logic        valid;
   } mnx_instr_t;

   typedef struct packed {
      logic [7:0] high;
      logic [7:0] low;
   } mnx_prod_t;

   typedef enum logic [4:0] {
      MNX_OP_NONE = 5'h01,
      MNX_OP_MUL  = 5'h02,
      MNX_OP_NEG  = 5'h04,
      MNX_OP_POP  = 5'h08,
      MNX_OP_PUSH = 5'h10
   } mnx_op_t;
endpackage

/* File: design/mnx_bank_sel.sv */
`timescale 1ns/1ns
`include "mnx_consts.svh"
module mnx_bank_sel
   import mnx_pkg::*;
(
   input  wire logic [7:0] offset_in,
   input  wire logic       access_bit_in,
   input  wire logic [3:0] bank_select_register_in,
   output mnx_pkg::mnx_addr_t addr_out
);
   always_comb begin
      addr_out.offset = offset_in;
      if (access_bit_in) begin
         addr_out.bank = bank_select_register_in;
      end else if (offset_in < `MNX_ACCESS_SPLIT) begin
         addr_out.bank = `MNX_ACCESS_LOW;
      end else begin
         addr_out.bank = `MNX_ACCESS_HIGH;
      end
   end
endmodule

/* File: design/mnx_exec.sv */
`timescale 1ns/1ns
`include "mnx_consts.svh"
// Behaviour
// - multiply W by file into product pair
// - multiply keeps W, file, flags unchanged
// - access bit zero selects access bank
// - negate writes inverted plus one, flags
// - pop discards return stack top
// - push stores pc plus two on stack
module mnx_exec (
   input  wire logic                clk_in,
   input  wire logic                rst_n_in,
   input  mnx_pkg::mnx_instr_t      instr_in,
   input  wire logic [20:0]         pc_in,
   input  wire logic [7:0]          w_in,
   input  wire logic [3:0]          bank_select_register_in,
   input  wire logic [7:0]          file_rdata_in,
   output mnx_pkg::mnx_addr_t       file_addr_out,
   output logic [7:0]               file_wdata_out,
   output logic                     file_we_out,
   output mnx_pkg::mnx_prod_t       prod_out,
   output logic [4:0]               status_out,
   output logic [20:0]              return_stack_top_out,
   output logic [`MNX_SP_W-1:0]     stack_ptr_out
);
   import mnx_pkg::*;

   mnx_op_t             op;
   mnx_addr_t           addr_c;
   mnx_prod_t           prod_d, prod_q;
   logic [4:0]          status_d, status_q;
   logic [7:0]          neg_res;
   logic [15:0]         mul_full;
   logic [7:0]          wdata_d, wdata_q;
   logic                we_d, we_q;
   mnx_addr_t           waddr_d, waddr_q;
   logic [`MNX_SP_W-1:0] sp_d, sp_q;
   logic [20:0]         stack_d [1:`MNX_STACK_DEPTH];
   logic [20:0]         stack_q [1:`MNX_STACK_DEPTH];
   logic [20:0]         tos_d, tos_q;

   mnx_bank_sel u_bank (
      .offset_in               (instr_in.word[7:0]),
      .access_bit_in           (instr_in.word[8]),
      .bank_select_register_in (bank_select_register_in),
      .addr_out                (addr_c)
   );

   always_comb begin
      op = MNX_OP_NONE;
      if (instr_in.valid) begin
         // an all-ones top nibble is the tail of a two-word op; run alone it does nothing
         if (instr_in.word[15:12] == `MNX_NOP_NIBBLE || instr_in.word == `MNX_OPC_NOP) begin
            op = MNX_OP_NONE;
         end else if (instr_in.word[15:9] == `MNX_OPC_MUL_HI) begin
            op = MNX_OP_MUL;
         end else if (instr_in.word[15:9] == `MNX_OPC_NEG_HI) begin
            op = MNX_OP_NEG;
         end else if (instr_in.word == `MNX_OPC_POP) begin
            op = MNX_OP_POP;
         end else if (instr_in.word == `MNX_OPC_PUSH) begin
            op = MNX_OP_PUSH;
         end
      end
   end

   // both operands widened first so the upper byte of the product survives
   assign mul_full = {8'h00, w_in} * {8'h00, file_rdata_in};

   assign neg_res = 8'h00 - file_rdata_in;

   always_comb begin
      prod_d   = prod_q;
      status_d = status_q;
      wdata_d  = wdata_q;
      we_d     = 1'b0;
      waddr_d  = waddr_q;
      case (op)
         MNX_OP_MUL: begin
            prod_d = mul_full;
         end
         MNX_OP_NEG: begin
            we_d    = 1'b1;
            waddr_d = addr_c;
            wdata_d = ~file_rdata_in + 8'h01;
            status_d[`MNX_FLAG_N]  = neg_res[7];
            status_d[`MNX_FLAG_Z]  = (neg_res == 8'h00);
            status_d[`MNX_FLAG_OV] = (file_rdata_in == `MNX_NEG_OVF_VAL);
            status_d[`MNX_FLAG_C]  = (file_rdata_in == 8'h00);
            status_d[`MNX_FLAG_DC] = (file_rdata_in[3:0] == 4'h0);
         end
         default: begin
         end
      endcase
   end

   // slot 1 holds the oldest entry; a push at full depth overwrites the top slot
   always_comb begin
      sp_d  = sp_q;
      tos_d = tos_q;
      for (int i = 1; i <= `MNX_STACK_DEPTH; i++) begin
         stack_d[i] = stack_q[i];
      end
      case (op)
         MNX_OP_PUSH: begin
            if (sp_q != `MNX_SP_W'(`MNX_STACK_DEPTH)) begin
               sp_d = sp_q + `MNX_SP_W'(1);
            end
            tos_d = pc_in + `MNX_PC_STEP;
            stack_d[sp_d] = pc_in + `MNX_PC_STEP;
         end
         MNX_OP_POP: begin
            if (sp_q != '0) begin
               sp_d = sp_q - `MNX_SP_W'(1);
            end
            tos_d = (sp_d == '0) ? 21'h000000 : stack_q[sp_d];
         end
         default: begin
         end
      endcase
   end

   always_ff @(posedge clk_in) begin
      if (!rst_n_in) begin
         prod_q   <= '0;
         status_q <= '0;
         wdata_q  <= '0;
         we_q     <= 1'b0;
         waddr_q  <= '0;
         sp_q     <= '0;
         tos_q    <= '0;
         for (int i = 1; i <= `MNX_STACK_DEPTH; i++) begin
            stack_q[i] <= '0;
         end
      end else begin
         prod_q   <= prod_d;
         status_q <= status_d;
         wdata_q  <= wdata_d;
         we_q     <= we_d;
         waddr_q  <= waddr_d;
         sp_q     <= sp_d;
         tos_q    <= tos_d;
         for (int i = 1; i <= `MNX_STACK_DEPTH; i++) begin
            stack_q[i] <= stack_d[i];
         end
      end
   end

   assign file_addr_out        = waddr_q;
   assign file_wdata_out       = wdata_q;
   assign file_we_out          = we_q;
   assign prod_out             = prod_q;
   assign status_out           = status_q;
   assign return_stack_top_out = tos_q;
   assign stack_ptr_out        = sp_q;

   property p_mul_result;
      @(posedge clk_in) disable iff (!rst_n_in)
      (op == MNX_OP_MUL)
      |=> (prod_q == {8'h00, $past(w_in)} * {8'h00, $past(file_rdata_in)});
   endproperty
   a_mul_product: assert property (p_mul_result) else $error("product wrong");

   a_mul_flags_kept: assert property (@(posedge clk_in) disable iff (!rst_n_in)
      (op == MNX_OP_MUL) |=> ($stable(status_q) && !we_q)) else $error("multiply side effect");

   a_bank_access: assert property (@(posedge clk_in) disable iff (!rst_n_in)
      (op == MNX_OP_NEG && instr_in.word[8]) |=> (waddr_q.bank == $past(bank_select_register_in)))
      else $error("bank select ignored");

   a_bank_low: assert property (@(posedge clk_in) disable iff (!rst_n_in)
      (op == MNX_OP_NEG && !instr_in.word[8])
      |=> (waddr_q.offset == $past(instr_in.word[7:0])
         && waddr_q.bank == ($past(instr_in.word[7]) ? `MNX_ACCESS_HIGH : `MNX_ACCESS_LOW)))
      else $error("access bank wrong");

   a_neg_value: assert property (@(posedge clk_in) disable iff (!rst_n_in)
      (op == MNX_OP_NEG) |=> (we_q && (wdata_q + $past(file_rdata_in) == 8'h00)
         && status_q[`MNX_FLAG_Z] == (wdata_q == 8'h00))) else $error("negate wrong");

   a_neg_flags: assert property (@(posedge clk_in) disable iff (!rst_n_in)
      (op == MNX_OP_NEG)
      |=> (status_q[`MNX_FLAG_N] == wdata_q[7]
         && status_q[`MNX_FLAG_C] == ($past(file_rdata_in) == 8'h00)
         && status_q[`MNX_FLAG_OV] == ($past(file_rdata_in) == `MNX_NEG_OVF_VAL)
         && status_q[`MNX_FLAG_DC] == ($past(file_rdata_in[3:0]) == 4'h0)))
      else $error("negate flags wrong");

   sequence s_pushed;
      (op == MNX_OP_PUSH && sp_q == '0) ##1 (tos_q == $past(pc_in) + `MNX_PC_STEP);
   endsequence
   a_push_pop: assert property (@(posedge clk_in) disable iff (!rst_n_in)
      s_pushed ##0 (op == MNX_OP_POP) |=> (sp_q == '0)) else $error("pop wrong");

   a_pop_depth: assert property (@(posedge clk_in) disable iff (!rst_n_in)
      (op == MNX_OP_POP && sp_q != '0)
      |=> (sp_q == $past(sp_q) - 5'h01 && $stable(status_q) && $stable(prod_q) && !we_q))
      else $error("pop changed more than the stack");

   a_pop_empty: assert property (@(posedge clk_in) disable iff (!rst_n_in)
      (op == MNX_OP_POP && sp_q == '0) |=> (sp_q == '0 && tos_q == 21'h000000))
      else $error("pop on empty stack");

   a_push_top: assert property (@(posedge clk_in) disable iff (!rst_n_in)
      (op == MNX_OP_PUSH) |=> (tos_q == $past(pc_in) + `MNX_PC_STEP)) else $error("push wrong");

   a_push_depth: assert property (@(posedge clk_in) disable iff (!rst_n_in)
      (op == MNX_OP_PUSH && sp_q != 5'h1f)
      |=> (sp_q == $past(sp_q) + 5'h01 && $stable(status_q) && $stable(prod_q)))
      else $error("push depth wrong");

   a_push_full: assert property (@(posedge clk_in) disable iff (!rst_n_in)
      (op == MNX_OP_PUSH && sp_q == 5'h1f) |=> (sp_q == 5'h1f)) else $error("push past full");

   // a push below full depth followed by a pop hands back the entry that was on top before the push
   sequence s_push_then_pop;
      (op == MNX_OP_PUSH && sp_q != 5'h1f) ##1 (op == MNX_OP_POP);
   endsequence
   a_stack_order: assert property (@(posedge clk_in) disable iff (!rst_n_in)
      s_push_then_pop |=> (tos_q == $past(tos_q, 2))) else $error("stack order wrong");

   a_nop_quiet: assert property (@(posedge clk_in) disable iff (!rst_n_in)
      (op == MNX_OP_NONE) |=> ($stable(prod_q) && $stable(status_q) && $stable(sp_q)
         && $stable(tos_q) && !we_q))
      else $error("no-operation changed state");
endmodule

/* File: bench/mnx_exec_bench.sv */
`timescale 1ns/1ns
module mnx_exec_bench;
   import mnx_pkg::*;
   logic        clk_in;
   logic        rst_n_in;
   mnx_instr_t  instr;
   logic [20:0] pc;
   logic [7:0]  w;
   logic [7:0]  rdata;
   logic [3:0]  bank_select_register;
   mnx_addr_t   faddr;
   logic [7:0]  fwd;
   logic        fwe;
   mnx_prod_t   prod;
   logic [4:0]  st;
   logic [20:0] return_stack_top;
   logic [4:0]  sp;
   int          error_cnt;
   int          checks;

   mnx_exec mnx_exec_i (
      .clk_in                  (clk_in),
      .rst_n_in                (rst_n_in),
      .instr_in                (instr),
      .pc_in                   (pc),
      .w_in                    (w),
      .bank_select_register_in (bank_select_register),
      .file_rdata_in           (rdata),
      .file_addr_out           (faddr),
      .file_wdata_out          (fwd),
      .file_we_out             (fwe),
      .prod_out                (prod),
      .status_out              (st),
      .return_stack_top_out    (return_stack_top),
      .stack_ptr_out           (sp)
   );

   initial begin
      clk_in = 1'b0;
      forever #10 clk_in = ~clk_in;
   end

   task automatic chk(input logic [20:0] got, input logic [20:0] exp);
      checks++;
      if (got !== exp) begin
         error_cnt++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   // one instruction taken at the next rising edge, results settled at the falling edge after
   task automatic run(input logic [15:0] word, input logic vld);
      @(negedge clk_in);
      instr = '{word, vld};
      @(negedge clk_in);
      instr.valid = 1'b0;
   endtask

   // two instructions on consecutive rising edges, both results settled on return
   task automatic run2(input logic [15:0] first, input logic [15:0] second);
      @(negedge clk_in);
      instr = '{first, 1'b1};
      @(negedge clk_in);
      instr = '{second, 1'b1};
      @(negedge clk_in);
      instr.valid = 1'b0;
   endtask

   task automatic t_mul(input logic [15:0] word, input logic [7:0] a, input logic [7:0] b);
      logic [4:0] st0;
      st0 = st;
      w = a;
      rdata = b;
      run(word, 1'b1);
      chk(21'(prod), 21'({8'h00, a} * {8'h00, b}));
      chk(21'(st), 21'(st0));
      chk(21'(fwe), 21'(1'b0));
   endtask

   task automatic t_neg(input logic [15:0] word, input logic [3:0] sel, input logic [7:0] src,
                        input logic [3:0] bank, input logic [7:0] res, input logic [4:0] flags);
      bank_select_register = sel;
      rdata = src;
      run(word, 1'b1);
      chk(21'(fwe), 21'(1'b1));
      chk(21'(fwd), 21'(res));
      chk(21'(faddr), 21'({bank, word[7:0]}));
      chk(21'(st), 21'(flags));
      @(negedge clk_in);
      chk(21'(fwe), 21'(1'b0));
   endtask

   task automatic t_stack();
      logic [4:0]  st0;
      logic [15:0] prod0;
      pc = 21'h000124;
      run(16'h0005, 1'b1);
      chk(return_stack_top, 21'h000126);
      chk(21'(sp), 21'h000001);
      pc = 21'h003000;
      run(16'h0005, 1'b1);
      chk(return_stack_top, 21'h003002);
      chk(21'(sp), 21'h000002);
      st0 = st;
      prod0 = prod;
      run(16'h0000, 1'b1);
      run(16'hf123, 1'b1);
      run(16'h0005, 1'b0);
      chk(return_stack_top, 21'h003002);
      chk(21'(sp), 21'h000002);
      chk(21'(st), 21'(st0));
      chk(21'(prod), 21'(prod0));
      chk(21'(fwe), 21'(1'b0));
      run(16'h0006, 1'b1);
      chk(return_stack_top, 21'h000126);
      chk(21'(sp), 21'h000001);
      chk(21'(st), 21'(st0));
      run(16'h0006, 1'b1);
      chk(21'(sp), 21'h000000);
      chk(return_stack_top, 21'h000000);
   endtask

   // pop on empty, push then pop back to back, fill past the top, push then pop when deep
   task automatic t_stack_limits();
      pc = 21'h000200;
      run(16'h0006, 1'b1);
      chk(21'(sp), 21'h000000);
      chk(return_stack_top, 21'h000000);
      run2(16'h0005, 16'h0006);
      chk(21'(sp), 21'h000000);
      chk(return_stack_top, 21'h000000);
      for (int i = 1; i <= 32; i++) begin
         pc = 21'(i * 4);
         run(16'h0005, 1'b1);
      end
      chk(21'(sp), 21'h00001f);
      chk(return_stack_top, 21'h000082);
      run(16'h0006, 1'b1);
      chk(21'(sp), 21'h00001e);
      chk(return_stack_top, 21'h00007a);
      pc = 21'h000300;
      run2(16'h0005, 16'h0006);
      chk(21'(sp), 21'h00001e);
      chk(return_stack_top, 21'h00007a);
   endtask

   // reset in mid-run with a deep stack, then the stack restarts from empty
   task automatic t_reset();
      @(negedge clk_in);
      rst_n_in = 1'b0;
      repeat (2) @(negedge clk_in);
      rst_n_in = 1'b1;
      pc = 21'h000040;
      run(16'h0005, 1'b1);
      chk(return_stack_top, 21'h000042);
      chk(21'(sp), 21'h000001);
      run(16'h0006, 1'b1);
      chk(return_stack_top, 21'h000000);
      chk(21'(sp), 21'h000000);
   endtask

   task automatic finish_test();
      $display("checks=%0d error_cnt=%0d", checks, error_cnt);
      if (error_cnt == 0 && checks > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask

   initial begin
      error_cnt = 0;
      checks = 0;
      rst_n_in = 1'b0;
      instr = '{16'h0000, 1'b0};
      pc = 21'h000000;
      w = 8'h00;
      rdata = 8'h00;
      bank_select_register = 4'h3;
      repeat (8) @(negedge clk_in);
      rst_n_in = 1'b1;
      t_neg(16'h6d10, 4'h3, 8'h3a, 4'h3, 8'hc6, 5'h10);
      t_neg(16'h6dff, 4'hc, 8'h10, 4'hc, 8'hf0, 5'h12);
      t_mul(16'h0205, 8'hc4, 8'hb5);
      t_mul(16'h0305, 8'hff, 8'hff);
      t_neg(16'h6c10, 4'h5, 8'h80, 4'h0, 8'h80, 5'h1a);
      t_neg(16'h6c90, 4'h5, 8'h00, 4'hf, 8'h00, 5'h07);
      t_stack();
      t_stack_limits();
      t_reset();
      finish_test();
   end
endmodule
